// [hdl/vmlu_lane.sv]
// one lane: multiply, accumulator load and clamped result
// purely combinational; the caller registers both outputs
`include "vmlu_map.svh"

module vmlu_lane (
  // operation and operands
  input  wire vmlu_pkg::vmlu_op_type op,
  input  wire logic [15:0]           opA,
  input  wire logic [15:0]           opB,
  input  wire logic [47:0]           accOld,
  // results
  output logic      [47:0]           accNew,
  output logic      [15:0]           laneResult
);

  logic signed [31:0] product;
  logic        [31:0] quantSum;
  logic        [47:0] accHi;
  logic        [47:0] accQ;
  logic        [47:0] fracLoad;

  assign product  = $signed(opA) * $signed(opB);
  // negative products get the rounding bias before loading
  assign quantSum = product + (product[31] ? `VMLU_MULQ_RND : 32'h0);
  assign accHi    = {{16{accNew[47]}}, accNew[47:16]};
  assign accQ     = {{17{accNew[47]}}, accNew[47:17]};
  assign fracLoad = {product[30:0], 1'b0, accOld[15:0]}
                    + `VMLU_MULF_RND;

  // signed saturation of a sign-extended value to 16 bits
  function automatic logic [15:0] satS(input logic [47:0] v);
    if (&v[47:15] || ~|v[47:15]) begin
      satS = v[15:0];
    end else begin
      satS = v[47] ? `VMLU_SAT_NEG : `VMLU_SAT_POS;
    end
  endfunction : satS

  function automatic logic [15:0] satU(input logic [47:0] v);
    if (v[47]) begin
      satU = 16'h0000;
    end else if (|v[46:16]) begin
      satU = `VMLU_USAT_MAX;
    end else begin
      satU = v[15:0];
    end
  endfunction : satU

  // accumulator load; bits outside the written field keep their value
  always_comb begin
    accNew = accOld;
    case (op)
      vmlu_pkg::VMLU_OP_MUDL: begin
        accNew = {accOld[47:32], {16{product[31]}}, product[31:16]};
      end
      vmlu_pkg::VMLU_OP_MUDM: begin
        accNew = {accOld[47:32], product};
      end
      vmlu_pkg::VMLU_OP_MUDN: begin
        accNew = {accOld[47:32], product};
      end
      vmlu_pkg::VMLU_OP_MULF, vmlu_pkg::VMLU_OP_MULU: begin
        accNew = fracLoad;
      end
      vmlu_pkg::VMLU_OP_MULQ: begin
        accNew = {quantSum, accOld[15:0]};
      end
      default: begin
        accNew = accOld;
      end
    endcase
  end

  // clamped result of the value just loaded; kept apart from the load
  // so that no process reads back its own output
  always_comb begin
    laneResult = 16'h0000;
    case (op)
      vmlu_pkg::VMLU_OP_MUDL, vmlu_pkg::VMLU_OP_MUDN: begin
        laneResult = satS(accNew);
      end
      vmlu_pkg::VMLU_OP_MUDM: begin
        laneResult = satS(accHi);
      end
      vmlu_pkg::VMLU_OP_MULF: begin
        laneResult = satS(accHi);
      end
      vmlu_pkg::VMLU_OP_MULU: begin
        laneResult = satU(accHi);
      end
      vmlu_pkg::VMLU_OP_MULQ: begin
        laneResult = satS(accQ) & `VMLU_MULQ_MASK;
      end
      default: begin
        laneResult = 16'h0000;
      end
    endcase
  end

endmodule : vmlu_lane

// [hdl/vmlu_unit.sv]
// eight-lane vector multiply-load datapath with per-lane accumulator
// assumes operands arrive on the processor clock with the instruction
//
// Summary of operation
// - eight lanes multiply 16-bit elements, 32-bit products
// - selector zero: second operand from same lane
// - selector 001x: broadcast within lane pairs
// - selector 01xx: broadcast within lane quads
// - selector 1xxx: one element to all lanes
// - low partial: sign-extended product high half loaded
// - low and fraction-integer: clamp accumulator bits 15:0
// - integer-fraction mid: load product, clamp 31:16
// - fraction-integer mid: load full product
// - fraction multiplies: product shifted, then rounded
// - signed fraction: signed clamp of bits 31:16
// - unsigned fraction: unsigned clamp of bits 31:16
// - quantize: bias negative products by 32
// - quantize: clamp bits 32:17, clear low nibble
`include "vmlu_map.svh"

module vmlu_unit #(
  parameter int LANES = 8,
  parameter int EW    = 16,
  parameter int AW    = 48
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // instruction issue
  input  wire logic                issueValid,
  input  wire logic [31:0]         instrWord,
  // operands from the vector file
  input  wire logic [LANES*EW-1:0] srcAVector,
  input  wire logic [LANES*EW-1:0] srcBVector,
  // write-back to the vector file
  output logic                     resultValid_r,
  output logic      [4:0]          dstIndex_r,
  output logic      [LANES*EW-1:0] dstVector_r,
  output logic                     notHandled_r,
  // accumulator state
  output logic      [LANES*AW-1:0] laneProductSum_r
);

  logic                  inClass;
  logic [5:0]            funcCode;
  logic [3:0]            sel;
  logic                  doOp;
  vmlu_pkg::vmlu_op_type opDec;
  logic [LANES*EW-1:0]   laneResFlat;
  logic [LANES*AW-1:0]   accNewFlat;
  logic [EW-1:0]         laneB [LANES];
  logic [2:0]            bIdx  [LANES];

  // decode
  assign inClass  = (instrWord[`VMLU_OPC_HI:`VMLU_OPC_LO] == `VMLU_CLASS_OPCODE)
                    && instrWord[`VMLU_CLASS_BIT];
  assign funcCode = instrWord[`VMLU_FUNC_HI:`VMLU_FUNC_LO];
  assign sel      = instrWord[`VMLU_SEL_HI:`VMLU_SEL_LO];
  assign opDec    = !inClass                      ? vmlu_pkg::VMLU_OP_NONE :
                    (funcCode == `VMLU_FN_MULF)   ? vmlu_pkg::VMLU_OP_MULF :
                    (funcCode == `VMLU_FN_MULU)   ? vmlu_pkg::VMLU_OP_MULU :
                    (funcCode == `VMLU_FN_MULQ)   ? vmlu_pkg::VMLU_OP_MULQ :
                    (funcCode == `VMLU_FN_MUDL)   ? vmlu_pkg::VMLU_OP_MUDL :
                    (funcCode == `VMLU_FN_MUDM)   ? vmlu_pkg::VMLU_OP_MUDM :
                    (funcCode == `VMLU_FN_MUDN)   ? vmlu_pkg::VMLU_OP_MUDN :
                                                    vmlu_pkg::VMLU_OP_NONE;
  assign doOp     = issueValid && (opDec != vmlu_pkg::VMLU_OP_NONE);

  genvar k;
  generate
    for (k = 0; k < LANES; k++) begin : g_lane
      localparam logic [2:0] LANE = 3'(k);
      // selector code 0001 has no broadcast form; it reads as a full vector
      assign bIdx[k] = (sel == 4'h0)         ? LANE :
                       (sel[3:1] == 3'b001)  ? {LANE[2:1], sel[0]} :
                       (sel[3:2] == 2'b01)   ? {LANE[2], sel[1:0]} :
                       sel[3]                ? sel[2:0] :
                                               LANE;
      assign laneB[k] = srcBVector[32'(bIdx[k]) * EW +: EW];
      vmlu_lane u_lane (
        .op         (opDec),
        .opA        (srcAVector[k*EW +: EW]),
        .opB        (laneB[k]),
        .accOld     (laneProductSum_r[k*AW +: AW]),
        .accNew     (accNewFlat[k*AW +: AW]),
        .laneResult (laneResFlat[k*EW +: EW])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      resultValid_r    <= 1'b0;
      notHandled_r     <= 1'b0;
      dstIndex_r       <= 5'h00;
      dstVector_r      <= '0;
      laneProductSum_r <= '0;
    end else begin
      resultValid_r <= doOp;
      notHandled_r  <= issueValid && (opDec == vmlu_pkg::VMLU_OP_NONE);
      if (doOp) begin
        dstIndex_r       <= instrWord[`VMLU_DST_HI:`VMLU_DST_LO];
        dstVector_r      <= laneResFlat;
        laneProductSum_r <= accNewFlat;
      end
    end
  end

  // checks on lane 0 and the broadcast network
  logic signed [31:0] prod0;
  logic        [47:0] acc0;
  logic        [15:0] dst0;
  assign prod0 = $signed(srcAVector[EW-1:0]) * $signed(laneB[0]);
  assign acc0  = laneProductSum_r[AW-1:0];
  assign dst0  = dstVector_r[EW-1:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_issue(vmlu_pkg::vmlu_op_type o);
    issueValid && opDec == o;
  endsequence

  sequence s_done;
    resultValid_r;
  endsequence

  property p_full_vec;
    (sel == 4'h0) |-> laneB[5] == srcBVector[5*EW +: EW];
  endproperty
  a_full_vec: assert property (p_full_vec)
    else $error("full vector mismatch");

  property p_pair;
    (sel[3:1] == 3'b001) |-> laneB[5] == srcBVector[(4+sel[0])*EW +: EW];
  endproperty
  a_pair: assert property (p_pair)
    else $error("pair broadcast mismatch");

  property p_quad;
    (sel[3:2] == 2'b01) |-> laneB[6] == srcBVector[(4+sel[1:0])*EW +: EW];
  endproperty
  a_quad: assert property (p_quad)
    else $error("quad broadcast mismatch");

  // lanes 0, 3 and 7 must agree and also carry the element that the selector names
  property p_whole;
    sel[3] |-> (laneB[0] == laneB[7]) && (laneB[3] == laneB[0])
      && (laneB[7] == srcBVector[sel[2:0]*EW +: EW]);
  endproperty
  a_whole: assert property (p_whole)
    else $error("whole broadcast mismatch");

  property p_mudl;
    s_issue(vmlu_pkg::VMLU_OP_MUDL) |=> s_done
      ##0 acc0[31:0] == {{16{$past(prod0[31])}}, $past(prod0[31:16])};
  endproperty
  a_mudl: assert property (p_mudl)
    else $error("low partial load wrong");

  property p_mudn;
    s_issue(vmlu_pkg::VMLU_OP_MUDN) |=> s_done
      ##0 acc0[31:0] == $past(prod0) && acc0[47:32] == $past(acc0[47:32]);
  endproperty
  a_mudn: assert property (p_mudn)
    else $error("mid load wrong");

  property p_mudm_load;
    s_issue(vmlu_pkg::VMLU_OP_MUDM) |=> s_done
      ##0 acc0[31:0] == $past(prod0) && acc0[47:32] == $past(acc0[47:32]);
  endproperty
  a_mudm_load: assert property (p_mudm_load)
    else $error("integer fraction load wrong");

  property p_mulf;
    s_issue(vmlu_pkg::VMLU_OP_MULF) |=> s_done ##0 acc0 ==
      {$past(prod0[30:0]), 1'b0, $past(acc0[15:0])} + `VMLU_MULF_RND;
  endproperty
  a_mulf: assert property (p_mulf)
    else $error("fraction rounding wrong");

  // only negative products carry the bias; the low field is kept
  property p_mulq_bias;
    s_issue(vmlu_pkg::VMLU_OP_MULQ) |=> s_done ##0 acc0[47:16] ==
      $past(prod0) + ($past(prod0[31]) ? `VMLU_MULQ_RND : 32'h0)
      && acc0[15:0] == $past(acc0[15:0]);
  endproperty
  a_mulq_bias: assert property (p_mulq_bias)
    else $error("quantize bias wrong");

  property p_mulu_neg;
    s_issue(vmlu_pkg::VMLU_OP_MULU) |=> (acc0[47] |-> dst0 == 16'h0000);
  endproperty
  a_mulu_neg: assert property (p_mulu_neg)
    else $error("unsigned clamp wrong");

  property p_mulq_mask;
    s_issue(vmlu_pkg::VMLU_OP_MULQ) |=> s_done ##0 dst0[3:0] == 4'h0;
  endproperty
  a_mulq_mask: assert property (p_mulq_mask)
    else $error("quantize mask wrong");

  property p_mudm_sat;
    s_issue(vmlu_pkg::VMLU_OP_MUDM) |=>
      (!acc0[47] && |acc0[46:31]) |-> dst0 == `VMLU_SAT_POS;
  endproperty
  a_mudm_sat: assert property (p_mudm_sat)
    else $error("signed clamp wrong");

  property p_refuse;
    issueValid && opDec == vmlu_pkg::VMLU_OP_NONE |=> notHandled_r
      && !resultValid_r && $stable(laneProductSum_r) && $stable(dstVector_r);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused instruction changed state");

  property p_index;
    doOp |=> resultValid_r && !notHandled_r
      && dstIndex_r == $past(instrWord[`VMLU_DST_HI:`VMLU_DST_LO]);
  endproperty
  a_index: assert property (p_index)
    else $error("write-back index wrong");

endmodule : vmlu_unit

// [pkg/vmlu_map.svh]
// constants for the vector multiply-load datapath
// assumes a single processor clock and operands read one cycle ahead
`ifndef VMLU_MAP_SVH
`define VMLU_MAP_SVH

// instruction word fields
`define VMLU_CLASS_OPCODE  6'h12
`define VMLU_OPC_HI        31
`define VMLU_OPC_LO        26
`define VMLU_CLASS_BIT     25
`define VMLU_SEL_HI        24
`define VMLU_SEL_LO        21
`define VMLU_DST_HI        10
`define VMLU_DST_LO        6
`define VMLU_FUNC_HI       5
`define VMLU_FUNC_LO       0

// function codes
`define VMLU_FN_MULF       6'h00
`define VMLU_FN_MULU       6'h01
`define VMLU_FN_MULQ       6'h03
`define VMLU_FN_MUDL       6'h04
`define VMLU_FN_MUDM       6'h05
`define VMLU_FN_MUDN       6'h06

// rounding, masking and clamp constants
`define VMLU_MULF_RND      48'h0000_0000_8000
`define VMLU_MULQ_RND      32'h0000_0020
`define VMLU_MULQ_MASK     16'hfff0
`define VMLU_SAT_POS       16'h7fff
`define VMLU_SAT_NEG       16'h8000
`define VMLU_USAT_MAX      16'hffff

`endif

// [pkg/vmlu_pkg.sv]
// types shared by the vector multiply-load datapath
// assumes vmlu_map.svh holds the numeric constants
package vmlu_pkg;

  typedef enum logic [2:0] {
    VMLU_OP_NONE,
    VMLU_OP_MULF,
    VMLU_OP_MULU,
    VMLU_OP_MULQ,
    VMLU_OP_MUDL,
    VMLU_OP_MUDM,
    VMLU_OP_MUDN
  } vmlu_op_type;

endpackage : vmlu_pkg

// [testbench/vector_multiply_load_unit_tb.sv]
// self-checking bench for the multiply-load datapath
// assumes the unit answers exactly one clock after taking a request
module vector_multiply_load_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk;
  logic         nrst;
  logic         issueValid;
  logic [31:0]  instrWord;
  logic [127:0] srcAVector;
  logic [127:0] srcBVector;
  logic         resultValid_r;
  logic [4:0]   dstIndex_r;
  logic [127:0] dstVector_r;
  logic         notHandled_r;
  logic [383:0] laneProductSum_r;
  logic [383:0] mAcc;
  logic [127:0] mDst;
  logic [127:0] expDst [$];
  logic [4:0]   mIdx;
  logic [5:0]   fn [6] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h06};
  int           mismatches;
  int           n_compared;

  vmlu_unit dut (.clk(clk), .nrst(nrst), .issueValid(issueValid),
    .instrWord(instrWord), .srcAVector(srcAVector),
    .srcBVector(srcBVector), .resultValid_r(resultValid_r),
    .dstIndex_r(dstIndex_r), .dstVector_r(dstVector_r),
    .notHandled_r(notHandled_r), .laneProductSum_r(laneProductSum_r));
  vmlu_issue_model mdl (.issueValid(issueValid), .instrWord(instrWord),
    .srcAVector(srcAVector), .srcBVector(srcBVector));

  always #25 clk = ~clk;

  task automatic check(input logic [383:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  function automatic logic [15:0] sat(input longint v);
    if (v > 32767) return 16'h7fff;
    if (v < -32768) return 16'h8000;
    return v[15:0];
  endfunction : sat

  function automatic logic [31:0] mkw(input logic [5:0] f,
                                      input logic [3:0] s);
    return {6'h12, 1'b1, s, 15'($urandom), f};
  endfunction : mkw

  // lanes mix extreme and random elements to reach the clamps
  function automatic logic [127:0] pick();
    logic [127:0] v;
    for (int i = 0; i < 8; i++) begin
      case ($urandom % 4)
        0: v[16*i+:16] = 16'h8000;
        1: v[16*i+:16] = 16'h7fff;
        2: v[16*i+:16] = 16'hffff;
        default: v[16*i+:16] = 16'($urandom);
      endcase
    end
    return v;
  endfunction : pick

  task automatic step(input logic [31:0] w, input logic [127:0] a, b);
    int j;
    longint p;
    longint sa;
    logic [47:0] ac;
    logic [3:0] s;
    s = w[24:21];
    for (int i = 0; i < 8; i++) begin
      j = s == 0 ? i : s[3:1] == 3'h1 ? s[0] + (i & 6) :
          s[3:2] == 2'h1 ? s[1:0] + (i & 4) : s[3] ? s[2:0] : i;
      p = $signed(a[16*i+:16]) * $signed(b[16*j+:16]);
      ac = mAcc[48*i+:48];
      case (w[5:0])
        6'h04: ac[31:0] = {{16{p[31]}}, p[31:16]};
        6'h05, 6'h06: ac[31:0] = p[31:0];
        6'h03: ac[47:16] = p[31:0] + (p < 0 ? 32'h20 : 32'h0);
        default: ac = {p[30:0], 1'b0, ac[15:0]} + 48'h8000;
      endcase
      sa = $signed(ac);
      mAcc[48*i+:48] = ac;
      case (w[5:0])
        6'h04, 6'h06: mDst[16*i+:16] = sat(sa);
        6'h03: mDst[16*i+:16] = sat(sa >>> 17) & 16'hfff0;
        6'h01: mDst[16*i+:16] = (sa >>> 16) < 0 ? 16'h0 :
            (sa >>> 16) > 65535 ? 16'hffff : sa[31:16];
        default: mDst[16*i+:16] = sat(sa >>> 16);
      endcase
    end
    mIdx = w[10:6];
  endtask : step

  // drive at a falling edge, judge at the next; callers may chain
  task automatic op(input logic [31:0] w, input logic [127:0] a, b);
    logic hd;
    logic [127:0] want;
    hd = w[31:25] == 7'h25 && w[5:0] inside {0, 1, 3, 4, 5, 6};
    mdl.send(w, a, b);
    if (hd) step(w, a, b);
    expDst.push_back(mDst);
    @(negedge clk);
    want = expDst.pop_front();
    check(resultValid_r, hd, "valid");
    check(notHandled_r, !hd, "refused");
    check(dstIndex_r, mIdx, "index");
    check(dstVector_r, want, "result");
    check(laneProductSum_r, mAcc, "acc");
  endtask : op

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    mismatches = 0;
    n_compared = 0;
    mAcc = '0;
    mDst = '0;
    mIdx = '0;
    void'($urandom(4410));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    check(laneProductSum_r, 0, "reset acc");
    for (int s = 0; s < 16; s++)
      foreach (fn[k]) op(mkw(fn[k], 4'(s)), pick(), pick());
    $display("test sweep done");
    op(mkw(6'h02, 4'h0), pick(), pick());
    op(mkw(6'h04, 4'h9) & 32'hfdff_ffff, pick(), pick());
    op(mkw(6'h00, 4'h3) ^ 32'h0400_0000, pick(), pick());
    op(mkw(6'h03, 4'h6), pick(), pick());
    mdl.idle();
    @(negedge clk);
    check(resultValid_r, 0, "pulse end");
    check(notHandled_r, 0, "refused end");
    $display("test refused done");
    op(mkw(6'h01, 4'h8), pick(), pick());
    nrst = 1'b0;
    mdl.idle();
    @(negedge clk);
    nrst = 1'b1;
    mAcc = '0;
    mDst = '0;
    mIdx = '0;
    check(laneProductSum_r, mAcc, "mid reset acc");
    check(dstVector_r, mDst, "mid reset dst");
    check(dstIndex_r, mIdx, "mid reset index");
    check(resultValid_r, 0, "mid reset valid");
    check(notHandled_r, 0, "mid reset refused");
    op(mkw(6'h05, 4'hf), pick(), pick());
    mdl.idle();
    $display("test reset done");
    summarize();
  end

  initial begin
    #(50ns * 5000);
    mismatches++;
    summarize();
  end
endmodule : vector_multiply_load_unit_tb

// [testbench/vmlu_issue_model.sv]
// partner model: issue logic and vector file feeding the multiply unit
// assumes the bench calls its tasks just after a falling clock edge
module vmlu_issue_model (
  // request toward the unit
  output logic         issueValid,
  output logic [31:0]  instrWord,
  output logic [127:0] srcAVector,
  output logic [127:0] srcBVector
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    issueValid = 1'b0;
    instrWord  = 32'h0;
    srcAVector = 128'h0;
    srcBVector = 128'h0;
  end

  task automatic send(input logic [31:0] w, input logic [127:0] a, b);
    issueValid = 1'b1;
    instrWord  = w;
    srcAVector = a;
    srcBVector = b;
  endtask : send

  // released lines show the inverse so stale operands are never trusted
  task automatic idle();
    issueValid = 1'b0;
    instrWord  = ~instrWord;
    srcAVector = ~srcAVector;
    srcBVector = ~srcBVector;
  endtask : idle
endmodule : vmlu_issue_model
